// ---- pkg/hibpr_pkg.sv ----
package hibpr_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam int unsigned ADDR_W        = 9;
  localparam logic [8:0]  OFS_COUNT     = 9'h000;
  localparam logic [8:0]  OFS_MATCH0    = 9'h004;
  localparam logic [8:0]  OFS_MATCH1    = 9'h008;
  localparam logic [8:0]  OFS_LOAD      = 9'h00c;
  localparam logic [8:0]  OFS_CTRL      = 9'h010;
  localparam logic [8:0]  OFS_MASK      = 9'h014;
  localparam logic [8:0]  OFS_RAW       = 9'h018;
  localparam logic [8:0]  OFS_MASKED    = 9'h01c;
  localparam logic [8:0]  OFS_CLEAR     = 9'h020;
  localparam logic [8:0]  OFS_TRIM      = 9'h024;
  localparam logic [8:0]  OFS_MEM_FIRST = 9'h030;
  localparam logic [8:0]  OFS_MEM_LAST  = 9'h12c;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned CTL_FIXED_BIT = 31;
  localparam int unsigned EV_MATCH0     = 0;
  localparam int unsigned EV_MATCH1     = 1;
  localparam int unsigned EV_BATT       = 2;
  localparam int unsigned EV_PIN        = 3;
  localparam int unsigned EV_W          = 4;
  localparam logic [31:0] RST_COUNT     = 32'h0000_0000;
  localparam logic [31:0] RST_MATCH     = 32'hffff_ffff;
  localparam logic [31:0] RST_LOAD      = 32'hffff_ffff;
  localparam logic [15:0] RST_TRIM      = 16'h7fff;
  localparam logic [3:0]  RST_EVENTS    = 4'h0;

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam logic [15:0] PREDIV_NOMINAL = 16'h7fff;
  localparam logic [5:0]  TRIM_SLOT      = 6'h3f;
  localparam logic [6:0]  XTAL_DIV_LAST  = 7'h7f;
  localparam int unsigned MEM_WORDS      = 64;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic batt_low_abort;
    logic osc_enable;
    logic battery_low_detect_enable;
    logic pin_resume_enable;
    logic match_resume_enable;
    logic osc_source_select;
    logic sleep_request;
    logic rtc_run_enable;
  } hibpr_ctl_type;

  typedef struct packed {
    logic pin;
    logic batt;
    logic match1;
    logic match0;
  } hibpr_event_type;

  typedef enum logic {
    HIBPR_AWAKE  = 1'b0,
    HIBPR_ASLEEP = 1'b1
  } hibpr_state_type;

endpackage : hibpr_pkg

// ---- rtl/hibpr_top.sv ----
`timescale 1ns/10ps

// What this block does
// - Drive power-off output low to switch regulator off on hibernation.
// - Asleep, wake on enabled resume pin low or enabled seconds match.
// - On wake release power-off output; returning supply resets the chip.
// - Crystal source: divide the fast input by 128 to get reference.
// - Oscillator enable starts reference; source select 0 crystal, 1 direct.
// - With detect enabled, low backup supply sets the raw battery flag.
// - With abort also set, low battery refuses entry into hibernation.
// - Battery level is not evaluated while hibernating.
// - 32-bit seconds counter advances when the down predivider ends.
// - Trim value is the divide count one second in every 64.
// - Trim above nominal slows counting, below nominal speeds it up.
// - Two 32-bit match registers wake the system or raise events.
// - Counter runs only with run enable; load write replaces it anytime.
// - Counter keeps running whether awake or hibernating.
// - 64 retained 32-bit words, readable and writable.
// - Sleep request bit starts hibernation; host enables a wake source.
// - Pin and match wake have separate enables, alone or together.
// - Pin, match and battery events OR into one interrupt line.
// - Raw status shows all pending events regardless of mask.
// - Mask selects interrupt sources; clear register clears events.
// - System reset clears registers only when run and pin enables clear.
module hibpr_top
  import hibpr_pkg::*;
#(
  parameter int unsigned WORDS = MEM_WORDS
) (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        sys_rst_i,
  input  wire logic [8:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        osc_clk_i,
  input  wire logic        resume_n_i,
  input  wire logic        batt_low_i,
  output logic             power_off_request_n_o,
  output logic             power_off_oe_o,
  output logic             irq_o
);

  // ****************************************************************
  // Address decoding helpers
  // ****************************************************************
  function automatic logic in_mem(input logic [8:0] a);
    in_mem = (a >= OFS_MEM_FIRST) && (a <= OFS_MEM_LAST) && (a[1:0] == 2'b00);
  endfunction : in_mem

  function automatic logic [5:0] mem_idx(input logic [8:0] a);
    logic [8:0] rel;
    rel     = a - OFS_MEM_FIRST;
    mem_idx = rel[7:2];
  endfunction : mem_idx

  // ****************************************************************
  // State
  // ****************************************************************
  hibpr_ctl_type   ctl_r;
  hibpr_state_type state_r, state_nxt;
  logic [31:0]     count_r, count_nxt;
  logic [31:0]     match0_r, match1_r, load_r;
  logic [15:0]     trim_r, prediv_r, prediv_nxt;
  logic [5:0]      slot_r;
  logic [6:0]      xdiv_r;
  logic [3:0]      raw_r, raw_nxt, mask_r, mask_nxt;
  logic            osc_q_r, resume_q_r;
  logic [31:0]     rdata_r;
  logic            pwr_n_r, pwr_oe_r, irq_r;
  logic [31:0]     mem_r [WORDS];

  // ****************************************************************
  // Register strobes
  // ****************************************************************
  wire logic ctl_wr   = wr_i && (addr_i == OFS_CTRL);
  wire logic load_wr  = wr_i && (addr_i == OFS_LOAD);
  wire logic m0_wr    = wr_i && (addr_i == OFS_MATCH0);
  wire logic m1_wr    = wr_i && (addr_i == OFS_MATCH1);
  wire logic trim_wr  = wr_i && (addr_i == OFS_TRIM);
  wire logic mask_wr  = wr_i && (addr_i == OFS_MASK);
  wire logic clr_wr   = wr_i && (addr_i == OFS_CLEAR);
  wire logic mem_wr   = wr_i && in_mem(addr_i);
  wire hibpr_ctl_type ctl_wdat = hibpr_ctl_type'(wdata_i[7:0]);

  // Registers survive a system reset unless nothing needs them
  wire logic soft_clr = sys_rst_i && !ctl_r.rtc_run_enable
                        && !ctl_r.pin_resume_enable;

  // ****************************************************************
  // Reference clock: direct or crystal divided by 128
  // ****************************************************************
  // Reference is sampled; the fast crystal sits well under core rate/2
  wire logic osc_rise = osc_clk_i && !osc_q_r && ctl_r.osc_enable;
  wire logic ref_tick = osc_rise && (ctl_r.osc_source_select ||
                        (xdiv_r == XTAL_DIV_LAST));

  // ****************************************************************
  // Predivider and seconds counter
  // ****************************************************************
  wire logic       run      = ctl_r.rtc_run_enable;
  wire logic       sec_tick = ref_tick && run && (prediv_r == 16'h0000);
  wire logic [5:0] slot_inc = slot_r + 6'h01;
  // Trim only sets the length of one second per 64; larger is slower
  wire logic [15:0] reload  = (slot_inc == TRIM_SLOT) ? trim_r
                                                      : PREDIV_NOMINAL;
  always_comb begin
    prediv_nxt = prediv_r;
    if (ref_tick && run) begin
      prediv_nxt = (prediv_r == 16'h0000) ? reload
                                          : prediv_r - 16'h0001;
    end
  end

  // Count advances regardless of sleep state
  always_comb begin
    count_nxt = count_r;
    if (load_wr) begin
      count_nxt = wdata_i;
    end else if (sec_tick) begin
      count_nxt = count_r + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // Match compare
  // ****************************************************************
  wire logic cnt_moved = load_wr || sec_tick;
  wire logic m0_hit = cnt_moved && (count_nxt == match0_r);
  wire logic m1_hit = cnt_moved && (count_nxt == match1_r);

  // ****************************************************************
  // Hibernation sequencing
  // ****************************************************************
  wire logic batt_refuse = ctl_wdat.batt_low_abort
                           && ctl_wdat.battery_low_detect_enable
                           && batt_low_i;
  wire logic go_sleep = ctl_wr && ctl_wdat.sleep_request
                        && !batt_refuse;
  wire logic pin_wake = ctl_r.pin_resume_enable && !resume_n_i;
  wire logic rtc_wake = ctl_r.match_resume_enable
                        && (m0_hit || m1_hit);
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      HIBPR_AWAKE: begin
        if (go_sleep) begin
          state_nxt = HIBPR_ASLEEP;
        end
      end
      HIBPR_ASLEEP: begin
        if (pin_wake || rtc_wake) begin
          state_nxt = HIBPR_AWAKE;
        end
      end
    endcase
  end

  // ****************************************************************
  // Events, mask and interrupt
  // ****************************************************************
  hibpr_event_type ev_set;
  always_comb begin
    ev_set.match0 = m0_hit;
    ev_set.match1 = m1_hit;
    // No battery sampling while power is cut
    ev_set.batt   = ctl_r.battery_low_detect_enable && batt_low_i
                    && (state_r == HIBPR_AWAKE);
    ev_set.pin    = resume_q_r && !resume_n_i;
  end
  // Set wins over a clear in the same cycle
  assign raw_nxt  = soft_clr ? RST_EVENTS
                  : (raw_r & ~(clr_wr ? wdata_i[3:0] : 4'h0))
                    | ev_set;
  assign mask_nxt = soft_clr ? RST_EVENTS
                  : (mask_wr ? wdata_i[3:0] : mask_r);

  // ****************************************************************
  // Read mux
  // ****************************************************************
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (in_mem(addr_i)) begin
      rd_word = mem_r[mem_idx(addr_i)];
    end else begin
      unique case (addr_i)
        OFS_COUNT:  rd_word = count_r;
        OFS_MATCH0: rd_word = match0_r;
        OFS_MATCH1: rd_word = match1_r;
        OFS_LOAD:   rd_word = load_r;
        OFS_CTRL: begin
          rd_word                = {24'h00_0000, ctl_r};
          rd_word[CTL_FIXED_BIT] = 1'b1;
        end
        OFS_MASK:   rd_word = {28'h000_0000, mask_r};
        OFS_RAW:    rd_word = {28'h000_0000, raw_r};
        OFS_MASKED: rd_word = {28'h000_0000, raw_r & mask_r};
        OFS_TRIM:   rd_word = {16'h0000, trim_r};
        default:    rd_word = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Control and timekeeping registers
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_r    <= '0;
      state_r  <= HIBPR_AWAKE;
      count_r  <= RST_COUNT;
      match0_r <= RST_MATCH;
      match1_r <= RST_MATCH;
      load_r   <= RST_LOAD;
      trim_r   <= RST_TRIM;
      prediv_r <= PREDIV_NOMINAL;
      slot_r   <= 6'h00;
      xdiv_r   <= 7'h00;
    end else if (soft_clr) begin
      ctl_r    <= '0;
      state_r  <= HIBPR_AWAKE;
      count_r  <= RST_COUNT;
      match0_r <= RST_MATCH;
      match1_r <= RST_MATCH;
      load_r   <= RST_LOAD;
      trim_r   <= RST_TRIM;
      prediv_r <= PREDIV_NOMINAL;
      slot_r   <= 6'h00;
      xdiv_r   <= 7'h00;
    end else begin
      if (ctl_wr) begin
        ctl_r <= ctl_wdat;
      end
      ctl_r.sleep_request <= (state_nxt == HIBPR_ASLEEP);
      state_r  <= state_nxt;
      count_r  <= count_nxt;
      prediv_r <= prediv_nxt;
      if (sec_tick) begin
        slot_r <= slot_inc;
      end
      if (osc_rise && !ctl_r.osc_source_select) begin
        xdiv_r <= xdiv_r + 7'h01;
      end
      if (m0_wr) match0_r <= wdata_i;
      if (m1_wr) match1_r <= wdata_i;
      if (load_wr) load_r <= wdata_i;
      if (trim_wr) trim_r <= wdata_i[15:0];
    end
  end

  // ****************************************************************
  // Status, pins and bus answer
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      raw_r      <= RST_EVENTS;
      mask_r     <= RST_EVENTS;
      osc_q_r    <= 1'b0;
      resume_q_r <= 1'b1;
      rdata_r    <= 32'h0000_0000;
      pwr_n_r    <= 1'b1;
      pwr_oe_r   <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      raw_r      <= raw_nxt;
      mask_r     <= mask_nxt;
      osc_q_r    <= osc_clk_i;
      resume_q_r <= resume_n_i;
      rdata_r    <= rd_i ? rd_word : 32'h0000_0000;
      // A clearing system reset also lets the regulator back on
      pwr_n_r    <= soft_clr || (state_nxt != HIBPR_ASLEEP);
      pwr_oe_r   <= !soft_clr && (state_nxt == HIBPR_ASLEEP);
      irq_r      <= |(raw_nxt & mask_nxt);
    end
  end

  // Retained words: no reset, contents must outlive any reset
  always_ff @(posedge core_clk_i) begin
    if (mem_wr) begin
      mem_r[mem_idx(addr_i)] <= wdata_i;
    end
  end

  assign rdata_o               = rdata_r;
  assign power_off_request_n_o = pwr_n_r;
  assign power_off_oe_o        = pwr_oe_r;
  assign irq_o                 = irq_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // Sleep entry and pin wake steps shared by the power checks
  sequence s_sleep_taken;
    go_sleep && state_r == HIBPR_AWAKE && !soft_clr;
  endsequence
  sequence s_pin_wake;
    state_r == HIBPR_ASLEEP && pin_wake && !soft_clr;
  endsequence

  power_off_a: assert property (s_sleep_taken |=>
    !power_off_request_n_o && power_off_oe_o [*1])
    else $error("power-off not asserted after sleep request");
  pin_wake_a: assert property (s_pin_wake |=>
    power_off_request_n_o ##1 power_off_request_n_o || ctl_r.sleep_request)
    else $error("pin wake did not restore power");
  match_wake_a: assert property (
    state_r == HIBPR_ASLEEP && rtc_wake && !soft_clr
    |=> power_off_request_n_o && raw_r[EV_MATCH0] | raw_r[EV_MATCH1])
    else $error("match wake did not restore power");
  batt_abort_a: assert property (
    ctl_wr && ctl_wdat.sleep_request && batt_refuse
    && state_r == HIBPR_AWAKE && !soft_clr |=> power_off_request_n_o)
    else $error("hibernation entered with low battery abort");
  batt_flag_a: assert property (ev_set.batt && !soft_clr
    |=> raw_r[EV_BATT])
    else $error("low battery flag not set");
  batt_asleep_a: assert property (
    state_r == HIBPR_ASLEEP && !raw_r[EV_BATT] |=> !raw_r[EV_BATT])
    else $error("battery evaluated while hibernating");
  count_step_a: assert property (
    sec_tick && !load_wr && !soft_clr
    |=> count_r == $past(count_r) + 32'h0000_0001)
    else $error("seconds counter did not advance");
  count_hold_a: assert property (
    !run && !load_wr && !soft_clr |=> $stable(count_r))
    else $error("counter moved while disabled");
  count_load_a: assert property (load_wr && !soft_clr
    |=> count_r == $past(wdata_i))
    else $error("load write did not replace counter");
  trim_slot_a: assert property (
    sec_tick && slot_inc == TRIM_SLOT && !trim_wr && !soft_clr
    |=> prediv_r == $past(trim_r))
    else $error("trim count not used for slot second");
  xtal_div_a: assert property (
    osc_rise && !ctl_r.osc_source_select && xdiv_r != XTAL_DIV_LAST
    |-> !ref_tick)
    else $error("crystal divider ticked early");
  irq_or_a: assert property (irq_o == |(raw_r & mask_r))
    else $error("interrupt not the OR of masked events");
  event_clear_a: assert property (
    clr_wr && wdata_i[EV_PIN] && !ev_set.pin && !soft_clr
    |=> !raw_r[EV_PIN])
    else $error("clear write left pin event pending");
  match_flag_a: assert property (m0_hit && !soft_clr && !m0_wr
    |=> raw_r[EV_MATCH0] && count_r == match0_r)
    else $error("match not flagged when counter met value");
  soft_reset_a: assert property (soft_clr
    |=> raw_r == RST_EVENTS && mask_r == RST_EVENTS && count_r == RST_COUNT)
    else $error("system reset did not clear registers");
  // Pin pair, quiet sleep, the second comparator and the all-clear mask
  oe_pair_a: assert property (
    power_off_oe_o == !power_off_request_n_o)
    else $error("open-drain enable not inverse of power-off level");
  asleep_hold_a: assert property (
    state_r == HIBPR_ASLEEP && !pin_wake && !rtc_wake && !soft_clr
    |=> !power_off_request_n_o && ctl_r.sleep_request)
    else $error("power restored without an enabled wake");
  match1_flag_a: assert property (m1_hit && !soft_clr && !m1_wr
    |=> raw_r[EV_MATCH1] && count_r == match1_r)
    else $error("match 1 not flagged when counter met value");
  irq_mask_a: assert property (mask_r == RST_EVENTS |-> !irq_o)
    else $error("interrupt raised with every event masked");

endmodule : hibpr_top

// ---- verif/hibpr_partner.sv ----
`timescale 1ns/10ps

// ****************************************************************
// External regulator and wake source on the power and resume pins
// ****************************************************************
module hibpr_partner (
  input  wire logic power_off_oe_i,
  input  wire logic wake_cmd_i,
  output logic      resume_n_o,
  output logic      supply_on_o
);
  // Open-drain pin with pull-up: supply is on unless the device pulls low
  assign supply_on_o = power_off_oe_i ? 1'b0 : 1'b1;
  // Resume pin rests at its pull-up; the source only pulls it low
  assign resume_n_o  = wake_cmd_i ? 1'b0 : 1'b1;
endmodule : hibpr_partner

// ---- verif/test_hibernation_power_rtc.sv ----
`timescale 1ns/10ps

module test_hibernation_power_rtc;
  import hibpr_pkg::*;

  // ****************************************************************
  // Signals and expected-value model
  // ****************************************************************
  localparam int unsigned SETTLE = 8; // Crystal settling wait, cycles
  localparam int unsigned GAP    = 2; // Write settling gap, cycles
  localparam logic [8:0]  RA [0:9] = '{OFS_COUNT, OFS_MATCH0, OFS_MATCH1,
    OFS_LOAD, OFS_CTRL, OFS_MASK, OFS_RAW, OFS_MASKED, OFS_TRIM, 9'h028};
  localparam logic [31:0] RV [0:9] = '{RST_COUNT, RST_MATCH, RST_MATCH,
    RST_LOAD, 32'h8000_0000, 32'h0, 32'h0, 32'h0, 32'h0000_7fff, 32'h0};

  logic        core_clk_i;
  logic        nrst_i;
  logic        sys_rst_i;
  logic [8:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        osc_ref;
  logic        resume_n_i;
  logic        batt_low_i;
  logic        power_off_request_n_o;
  logic        power_off_oe_o;
  logic        irq_o;
  logic        wake_cmd;
  logic        supply_on;
  int          err_count;
  int          comparisons;
  int          cyc;
  int unsigned exp_mem [$];
  logic [31:0] m [0:1];

  hibpr_top u_hibpr_top (
    .core_clk_i            (core_clk_i),
    .nrst_i                (nrst_i),
    .sys_rst_i             (sys_rst_i),
    .addr_i                (addr_i),
    .wdata_i               (wdata_i),
    .wr_i                  (wr_i),
    .rd_i                  (rd_i),
    .rdata_o               (rdata_o),
    .osc_clk_i             (osc_ref),
    .resume_n_i            (resume_n_i),
    .batt_low_i            (batt_low_i),
    .power_off_request_n_o (power_off_request_n_o),
    .power_off_oe_o        (power_off_oe_o),
    .irq_o                 (irq_o)
  );

  hibpr_partner u_hibpr_partner (
    .power_off_oe_i (power_off_oe_o),
    .wake_cmd_i     (wake_cmd),
    .resume_n_o     (resume_n_i),
    .supply_on_o    (supply_on)
  );

  // Clock at 100 ns; reference rises every 2 cycles to keep a second short
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    osc_ref <= nrst_i ? ~osc_ref : 1'b0;
  end

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Gap after every write keeps the host side of the timing contract
  task automatic reg_wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    repeat (GAP) @(posedge core_clk_i);
  endtask : reg_wr

  task automatic expect_rd(input string what, input logic [8:0] a,
                           input logic [31:0] exp);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(what, rdata_o, exp);
  endtask : expect_rd

  // Power pin pair and the regulator's view of it
  task automatic chk_pwr(input string what, input logic on);
    #1 chk(what, {29'h0, supply_on, power_off_oe_o, power_off_request_n_o},
           {29'h0, on, ~on, on});
  endtask : chk_pwr

  task automatic wake_pulse;
    @(posedge core_clk_i);
    wake_cmd <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    wake_cmd <= 1'b0;
  endtask : wake_pulse

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Watchdog: one counted second is 65,536 cycles, the rest under a thousand
  initial begin
    #(90000 * 100);
    err_count++;
    give_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {nrst_i, sys_rst_i, wr_i, rd_i, batt_low_i, wake_cmd} = 6'h0;
    addr_i = 9'h0;
    wdata_i = 32'h0;
    err_count = 0;
    comparisons = 0;
    void'($urandom(7706));
    repeat (20) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    chk_pwr("power after reset", 1'b1);
    for (int i = 0; i < 10; i++) expect_rd("reset value", RA[i], RV[i]);
    // Read data stands one cycle only, then returns to zero
    @(posedge core_clk_i);
    #1 chk("rdata idle", rdata_o, 32'h0);
    reg_wr(OFS_CTRL, 32'h40);
    repeat (SETTLE) @(posedge core_clk_i);
    // Retained words hold random data; counter ignores writes
    for (int i = 0; i < 64; i++) begin
      exp_mem.push_back($urandom());
      reg_wr(9'(int'(OFS_MEM_FIRST) + 4 * i), exp_mem[i]);
    end
    for (int i = 0; i < 64; i++)
      expect_rd("memory", 9'(int'(OFS_MEM_FIRST) + 4 * i), exp_mem[i]);
    reg_wr(OFS_COUNT, $urandom());
    expect_rd("count ro", OFS_COUNT, 32'h0);
    m[0] = {16'h0, 16'($urandom())};
    reg_wr(OFS_TRIM, m[0]);
    expect_rd("trim", OFS_TRIM, m[0]);
    // Each match register raises only its own event via a load
    m[0] = $urandom();
    m[1] = m[0] ^ 32'h0000_0100;
    reg_wr(OFS_MATCH0, m[0]);
    reg_wr(OFS_MATCH1, m[1]);
    for (int k = 0; k < 2; k++) begin
      reg_wr(OFS_LOAD, m[k]);
      expect_rd("count load", OFS_COUNT, m[k]);
      expect_rd("raw match", OFS_RAW, 32'h1 << k);
      chk("irq unmasked", {31'h0, irq_o}, 32'h0);
      reg_wr(OFS_MASK, 32'h1 << k);
      chk("irq masked", {31'h0, irq_o}, 32'h1);
      expect_rd("masked", OFS_MASKED, 32'h1 << k);
      reg_wr(OFS_CLEAR, 32'h1 << k);
      expect_rd("raw cleared", OFS_RAW, 32'h0);
      chk("irq cleared", {31'h0, irq_o}, 32'h0);
    end
    reg_wr(OFS_MASK, 32'hf);
    // Low battery: flag only with detect, abort refuses sleep
    @(posedge core_clk_i);
    batt_low_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    expect_rd("batt no detect", OFS_RAW, 32'h0);
    reg_wr(OFS_CTRL, 32'h60);
    expect_rd("batt raw", OFS_RAW, 32'h4);
    chk("batt irq", {31'h0, irq_o}, 32'h1);
    reg_wr(OFS_CTRL, 32'hf2);
    chk_pwr("abort sleep", 1'b1);
    @(posedge core_clk_i);
    batt_low_i <= 1'b0;
    reg_wr(OFS_CTRL, 32'h40);
    reg_wr(OFS_CLEAR, 32'hf);
    // Pin wake; battery not sampled while asleep
    reg_wr(OFS_CTRL, 32'h76);
    chk_pwr("pin sleep", 1'b0);
    @(posedge core_clk_i);
    batt_low_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    expect_rd("batt asleep", OFS_RAW, 32'h0);
    @(posedge core_clk_i);
    batt_low_i <= 1'b0;
    wake_pulse();
    chk_pwr("pin wake", 1'b1);
    expect_rd("raw pin", OFS_RAW, 32'h8);
    reg_wr(OFS_CLEAR, 32'hf);
    // Match wake alone: pin ignored, load to match ends sleep
    m[0] = $urandom();
    reg_wr(OFS_MATCH0, m[0]);
    reg_wr(OFS_CTRL, 32'h4e);
    wake_pulse();
    chk_pwr("pin disabled", 1'b0);
    reg_wr(OFS_CLEAR, 32'hf);
    reg_wr(OFS_LOAD, m[0]);
    chk_pwr("match wake", 1'b1);
    expect_rd("raw match wake", OFS_RAW, 32'h1);
    // System reset: ignored with pin enable, obeyed with both clear
    reg_wr(OFS_CTRL, 32'h50);
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk_i);
      sys_rst_i <= 1'b1;
      @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      expect_rd("sysrst match", OFS_MATCH0, k ? RST_MATCH : m[0]);
      reg_wr(OFS_CTRL, 32'h40);
    end
    expect_rd("sysrst mem", OFS_MEM_FIRST, exp_mem[0]);
    // Counting asleep: one second of direct reference ends sleep on match
    m[0] = {1'b0, 31'($urandom())};
    reg_wr(OFS_MATCH0, m[0] + 32'h1);
    reg_wr(OFS_LOAD, m[0]);
    reg_wr(OFS_CTRL, 32'h4f);
    chk_pwr("count sleep", 1'b0);
    cyc = 0;
    while (!power_off_request_n_o && cyc < 70000) begin
      @(posedge core_clk_i);
      #1 cyc++;
    end
    // 32768 ticks at 2 cycles each, less the write and return edges
    chk("second length", cyc / 4, 32'(PREDIV_NOMINAL) / 2);
    chk_pwr("count wake", 1'b1);
    expect_rd("count asleep", OFS_COUNT, m[0] + 32'h1);
    expect_rd("raw count match", OFS_RAW, 32'h1);
    give_verdict();
  end
endmodule : test_hibernation_power_rtc
